// *** logic/ftr_defines.vh ***
// constants for the thermal fault response and limit block
//
// Functional notes
// - word register holds low-voltage over-current trip level
// - word register holds over-current warning level
// - word register holds over-temperature trip level
// - thermal action register uses byte transfers only
// - action 00 keeps running through the fault
// - action 01 runs for delay, then follows retries
// - action 10 disables output, then follows retries
// - action 11 disables output until cleared
// - status clear, clear command, reset, off-on clear
// - retry code 000 means never restart
// - retry codes 1..6 try that often, then off
// - attempt starts spaced by delay count units
// - retry code 111 retries until commanded off
// - delay field counts external delay time units
// - delay code n means two to the n units
`ifndef FTR_DEFINES_VH
`define FTR_DEFINES_VH

// command codes
`define FTR_CMD_CLEAR_FAULTS 8'h03
`define FTR_CMD_LV_TRIP 8'h48
`define FTR_CMD_CUR_WARN 8'h4A
`define FTR_CMD_HOT_TRIP 8'h4F
`define FTR_CMD_HOT_ACTION 8'h50
`define FTR_CMD_STAT_CURRENT 8'h7B
`define FTR_CMD_STAT_TEMP 8'h7D

// action register fields
`define FTR_RESP_HI 7
`define FTR_RESP_LO 6
`define FTR_RETRY_HI 5
`define FTR_RETRY_LO 3
`define FTR_DELAY_HI 2
`define FTR_DELAY_LO 0

// response and retry codes
`define FTR_RESP_IGNORE 2'h0
`define FTR_RESP_DELAY 2'h1
`define FTR_RESP_RETRY 2'h2
`define FTR_RESP_LATCH 2'h3
`define FTR_RETRY_NONE 3'h0
`define FTR_RETRY_FOREVER 3'h7

// status bit positions
`define FTR_STAT_TEMP_OT_BIT 7
`define FTR_STAT_CUR_WARN_BIT 5

// reset values
`define FTR_RST_LV_TRIP 16'h0000
`define FTR_RST_CUR_WARN 16'h0BFF
`define FTR_RST_HOT_TRIP 16'h0BFF
`define FTR_RST_HOT_ACTION 8'h80

// linear format layout
`define FTR_LIN_EXP_HI 15
`define FTR_LIN_EXP_LO 11
`define FTR_LIN_MAN_HI 10
`define FTR_LIN_SHIFT_BIAS 6'h10

`endif

// *** logic/ftr_pin_sync.v ***
// three-stage synchroniser with agreement filter for outside inputs
`default_nettype none

module ftr_pin_sync (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // asynchronous input and its settled level
    input wire pin,
    output reg level
);

reg stage1;
reg stage2;
reg stage3;

// stage1 feeds stage2 only; level moves when stages 2 and 3 agree
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        stage1 <= 1'b0;
        stage2 <= 1'b0;
        stage3 <= 1'b0;
        level <= 1'b0;
    end else begin
        stage1 <= pin;
        stage2 <= stage1;
        stage3 <= stage2;
        if (stage2 == stage3) begin
            level <= stage3;
        end
    end
end

endmodule // ftr_pin_sync

`default_nettype wire

// *** logic/ftr_fault_ctrl.v ***
// thermal fault response sequencer with protection limit registers
`include "ftr_defines.vh"
`default_nettype none

module ftr_fault_ctrl (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // command port from the bus transport, same clock
    input wire cmd_valid,
    input wire cmd_write,
    input wire cmd_word,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    output reg rsp_valid,
    output reg rsp_error,
    output reg [15:0] rsp_rdata,
    // measurements in linear format, same clock
    input wire [15:0] temp_meas,
    input wire [15:0] current_meas,
    // on/off command sources
    input wire ctrl_pin,
    input wire op_on,
    // delay time unit clock from the timebase, other domain
    input wire unit_clk,
    // outputs to the power stage and status
    output reg out_enable,
    output reg hot_fault,
    output reg current_warn,
    output reg [15:0] lv_trip_level,
    output reg retry_busy
);

// sequencer states
localparam [2:0] ST_RUN = 3'h0;
localparam [2:0] ST_DELAY = 3'h1;
localparam [2:0] ST_OFF = 3'h2;
localparam [2:0] ST_TRY = 3'h3;
localparam [2:0] ST_LATCH = 3'h4;

////////////////////////////////////////////////////////////////////////
// helpers

// linear word to a common fixed-point scale for comparisons
function signed [47:0] lin_value;
    input [15:0] w;
    reg [5:0] amount;
    reg signed [47:0] man;
    begin
        amount = {w[`FTR_LIN_EXP_HI], w[`FTR_LIN_EXP_HI:`FTR_LIN_EXP_LO]}
            + `FTR_LIN_SHIFT_BIAS;
        man = {{37{w[`FTR_LIN_MAN_HI]}}, w[`FTR_LIN_MAN_HI:0]};
        lin_value = man <<< amount[4:0];
    end
endfunction

// delay code n gives 2 to the n units
function [7:0] delay_units;
    input [2:0] code;
    begin
        delay_units = 8'h01 << code;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// outside inputs

wire ctrl_level;
wire unit_level;
reg unit_prev;
wire unit_tick;

ftr_pin_sync u_ctrl_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin(ctrl_pin),
    .level(ctrl_level)
);

ftr_pin_sync u_unit_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin(unit_clk),
    .level(unit_level)
);

// one tick per delay time unit, taken from the unit clock rising edge
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        unit_prev <= 1'b0;
    end else begin
        unit_prev <= unit_level;
    end
end

assign unit_tick = unit_level & ~unit_prev;

////////////////////////////////////////////////////////////////////////
// limit and action registers

reg [15:0] cur_warn_limit;
reg [15:0] hot_limit;
reg [7:0] hot_action;
reg [7:0] next_rdata_lo;
reg [15:0] next_rdata;
reg next_error;
reg wr_lv;
reg wr_warn;
reg wr_hot;
reg wr_action;
reg clr_cmd;
reg clr_hot_bit;
reg clr_warn_bit;

// decode: word codes need word transfers, byte codes byte transfers
always @* begin
    next_rdata = 16'h0000;
    next_rdata_lo = 8'h00;
    next_error = 1'b0;
    wr_lv = 1'b0;
    wr_warn = 1'b0;
    wr_hot = 1'b0;
    wr_action = 1'b0;
    clr_cmd = 1'b0;
    clr_hot_bit = 1'b0;
    clr_warn_bit = 1'b0;
    case (cmd_code)
        `FTR_CMD_LV_TRIP: begin
            next_rdata = lv_trip_level;
            next_error = ~cmd_word;
            wr_lv = cmd_word & cmd_write;
        end
        `FTR_CMD_CUR_WARN: begin
            next_rdata = cur_warn_limit;
            next_error = ~cmd_word;
            wr_warn = cmd_word & cmd_write;
        end
        `FTR_CMD_HOT_TRIP: begin
            next_rdata = hot_limit;
            next_error = ~cmd_word;
            wr_hot = cmd_word & cmd_write;
        end
        `FTR_CMD_HOT_ACTION: begin
            next_rdata = {8'h00, hot_action};
            next_error = cmd_word;
            wr_action = ~cmd_word & cmd_write;
        end
        `FTR_CMD_CLEAR_FAULTS: begin
            next_error = cmd_word | ~cmd_write;
            clr_cmd = ~cmd_word & cmd_write;
        end
        `FTR_CMD_STAT_TEMP: begin
            next_rdata_lo[`FTR_STAT_TEMP_OT_BIT] = hot_fault;
            next_rdata = {8'h00, next_rdata_lo};
            next_error = cmd_word;
            clr_hot_bit = ~cmd_word & cmd_write &
                cmd_wdata[`FTR_STAT_TEMP_OT_BIT];
        end
        `FTR_CMD_STAT_CURRENT: begin
            next_rdata_lo[`FTR_STAT_CUR_WARN_BIT] = current_warn;
            next_rdata = {8'h00, next_rdata_lo};
            next_error = cmd_word;
            clr_warn_bit = ~cmd_word & cmd_write &
                cmd_wdata[`FTR_STAT_CUR_WARN_BIT];
        end
        default: begin
            next_error = 1'b1;
        end
    endcase
    if (!cmd_valid) begin
        wr_lv = 1'b0;
        wr_warn = 1'b0;
        wr_hot = 1'b0;
        wr_action = 1'b0;
        clr_cmd = 1'b0;
        clr_hot_bit = 1'b0;
        clr_warn_bit = 1'b0;
    end
end

// register writes and the one-cycle answer; refused writes store nothing
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        lv_trip_level <= `FTR_RST_LV_TRIP;
        cur_warn_limit <= `FTR_RST_CUR_WARN;
        hot_limit <= `FTR_RST_HOT_TRIP;
        hot_action <= `FTR_RST_HOT_ACTION;
        rsp_valid <= 1'b0;
        rsp_error <= 1'b0;
        rsp_rdata <= 16'h0000;
    end else begin
        if (wr_lv) begin
            lv_trip_level <= cmd_wdata;
        end
        if (wr_warn) begin
            cur_warn_limit <= cmd_wdata;
        end
        if (wr_hot) begin
            hot_limit <= cmd_wdata;
        end
        if (wr_action) begin
            hot_action <= cmd_wdata[7:0];
        end
        rsp_valid <= cmd_valid;
        rsp_error <= cmd_valid & next_error;
        rsp_rdata <= (cmd_valid & ~cmd_write & ~next_error) ?
            next_rdata : 16'h0000;
    end
end

////////////////////////////////////////////////////////////////////////
// comparisons and status flags

wire hot_now;
wire warn_now;
wire cmd_on;
reg cmd_on_prev;
wire off_seen;

// signed compare in a shared scale, so exponents may differ
assign hot_now = lin_value(temp_meas) >= lin_value(hot_limit);
assign warn_now = lin_value(current_meas) >
    lin_value(cur_warn_limit);
assign cmd_on = ctrl_level & op_on;
assign off_seen = cmd_on_prev & ~cmd_on;

// sticky warning; a new event in the clearing cycle survives
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        current_warn <= 1'b0;
        cmd_on_prev <= 1'b0;
    end else begin
        current_warn <= warn_now |
            (current_warn & ~clr_warn_bit & ~clr_cmd);
        cmd_on_prev <= cmd_on;
    end
end

////////////////////////////////////////////////////////////////////////
// response sequencer

reg [2:0] state;
reg [7:0] timer;
reg [2:0] tries;
reg [2:0] next_state;
reg [7:0] next_timer;
reg [2:0] next_tries;
reg hot_set;
wire [1:0] resp;
wire [2:0] retry_code;
wire [7:0] units;
wire clear_all;
wire expire;

assign resp = hot_action[`FTR_RESP_HI:`FTR_RESP_LO];
assign retry_code = hot_action[`FTR_RETRY_HI:`FTR_RETRY_LO];
assign units = delay_units(hot_action[`FTR_DELAY_HI:`FTR_DELAY_LO]);
// turning off (pin or operation) ends any latch or retry run
assign clear_all = clr_cmd | clr_hot_bit | off_seen | ~cmd_on;
assign expire = unit_tick && (timer == 8'h01);

// next state; a counted run ends latched once all attempts are spent
always @* begin
    next_state = state;
    next_timer = timer;
    next_tries = tries;
    hot_set = 1'b0;
    if (unit_tick && timer != 8'h00) begin
        next_timer = timer - 8'h01;
    end
    case (state)
        ST_RUN: begin
            if (hot_now) begin
                hot_set = 1'b1;
                next_tries = 3'h0;
                next_timer = units;
                case (resp)
                    `FTR_RESP_IGNORE: next_state = ST_RUN;
                    `FTR_RESP_DELAY: next_state = ST_DELAY;
                    `FTR_RESP_RETRY: begin
                        next_state = (retry_code == `FTR_RETRY_NONE) ?
                            ST_LATCH : ST_OFF;
                    end
                    default: next_state = ST_LATCH;
                endcase
            end
        end
        ST_DELAY: begin
            if (expire) begin
                next_timer = units;
                if (!hot_now) begin
                    next_state = ST_RUN;
                end else if (retry_code == `FTR_RETRY_NONE) begin
                    next_state = ST_LATCH;
                end else begin
                    next_state = ST_OFF;
                end
            end
        end
        ST_OFF: begin
            if (expire || timer == 8'h00) begin // failed on last tick
                // timer reloads at each attempt start
                next_state = ST_TRY;
                next_timer = units;
                next_tries = tries + 3'h1;
            end
        end
        ST_TRY: begin
            if (hot_now) begin
                hot_set = 1'b1;
                if (retry_code != `FTR_RETRY_FOREVER &&
                    tries >= retry_code) begin
                    next_state = ST_LATCH;
                end else begin
                    next_state = ST_OFF;
                end
            end else if (expire) begin
                next_state = ST_RUN;
                next_tries = 3'h0;
            end
        end
        ST_LATCH: begin
            next_state = ST_LATCH;
        end
        default: begin
            next_state = ST_RUN;
        end
    endcase
    if (clear_all) begin
        next_state = ST_RUN;
        next_timer = 8'h00;
        next_tries = 3'h0;
    end
end

// state, output enable and latched fault status all registered
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        state <= ST_RUN;
        timer <= 8'h00;
        tries <= 3'h0;
        out_enable <= 1'b0;
        hot_fault <= 1'b0;
        retry_busy <= 1'b0;
    end else begin
        state <= next_state;
        timer <= next_timer;
        tries <= next_tries;
        out_enable <= cmd_on && (next_state == ST_RUN ||
            next_state == ST_DELAY || next_state == ST_TRY);
        hot_fault <= (hot_set & cmd_on) |
            (hot_fault & ~clr_cmd & ~clr_hot_bit & ~off_seen);
        retry_busy <= (next_state == ST_OFF) || (next_state == ST_TRY);
    end
end

endmodule // ftr_fault_ctrl

`default_nettype wire

// *** verification/ftr_fault_ctrl_sva.sv ***
// checker for the thermal fault response block ports
`default_nettype none
module ftr_fault_ctrl_sva (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_word,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    // power stage and status
    input wire logic op_on,
    input wire logic out_enable,
    input wire logic hot_fault,
    input wire logic current_warn,
    input wire logic [15:0] lv_trip_level,
    input wire logic retry_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] resp;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // shadow of the response field; only byte writes can reach it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            resp <= 2'h2;
        else if (cmd_valid && cmd_write && !cmd_word && cmd_code == 8'h50)
            resp <= cmd_wdata[7:6];
    end
    ////////////////////////////////////////////////////////////
    a_rsp_next: assert property (cmd_valid |=> rsp_valid)
        else $error("no answer after command");
    a_byte_only: assert property (
        cmd_valid && cmd_word && cmd_code == 8'h50 |=> rsp_error)
        else $error("word access to action accepted");
    a_lv_export: assert property (
        cmd_valid && cmd_write && cmd_word && cmd_code == 8'h48
        |=> lv_trip_level == $past(cmd_wdata))
        else $error("trip level not exported");
    a_off_low: assert property (!op_on |=> !out_enable)
        else $error("output on while off");
    a_ignore_on: assert property (
        $rose(hot_fault) && resp == 2'h0 |-> out_enable)
        else $error("ignored fault dropped output");
    a_disable_now: assert property (
        $rose(hot_fault) && resp[1] |-> !out_enable)
        else $error("output on after disabling fault");
    a_latch_off: assert property (
        hot_fault && !out_enable && !retry_busy && !cmd_valid && op_on
        |=> !out_enable)
        else $error("latched output came back");
    a_warn_sticky: assert property (
        current_warn && !cmd_valid |=> current_warn)
        else $error("warning dropped without clear");
    c_latch: cover property ($rose(hot_fault) && resp == 2'h3);
    c_retry: cover property ($rose(retry_busy));
    c_refuse: cover property (rsp_valid && rsp_error);
endmodule // ftr_fault_ctrl_sva
bind ftr_fault_ctrl ftr_fault_ctrl_sva chk_u (.clk, .reset_n, .cmd_valid,
    .cmd_write, .cmd_word, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_error,
    .op_on, .out_enable, .hot_fault, .current_warn, .lv_trip_level,
    .retry_busy);
`default_nettype wire

// *** verification/ftr_host_model.sv ***
// host model driving the block's command port
`default_nettype none
module ftr_host_model (
    // clock
    input wire logic clk,
    // command and answer
    output var logic cmd_valid = 1'b0,
    output var logic cmd_write = 1'b0,
    output var logic cmd_word = 1'b0,
    output var logic [7:0] cmd_code = 8'h0,
    output var logic [15:0] cmd_wdata = 16'h0,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    input wire logic [15:0] rsp_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // held through the taking edge; data inverted after so a stale
    // value is never mistaken for a fresh one
    task automatic xfer(input logic wr, wd, input logic [7:0] c,
        input logic [15:0] d, output logic [15:0] rd, output logic er, ok);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_word <= wd; // action register in bytes only
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~d;
        #1;
        ok = rsp_valid;
        rd = rsp_rdata;
        er = rsp_error;
    endtask
endmodule // ftr_host_model
`default_nettype wire

// *** verification/ftr_fault_ctrl_tb_top.sv ***
// bench for the thermal fault response block
`default_nettype none
module ftr_fault_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic unit_clk = 1'b0;
    logic ctrl_pin = 1'b1;
    logic op_on = 1'b1;
    logic [15:0] temp_meas = 16'h0032;
    logic [15:0] current_meas = 16'h0;
    logic cmd_valid, cmd_write, cmd_word, rsp_valid, rsp_error;
    logic out_enable, hot_fault, current_warn, retry_busy;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata, lv_trip_level;
    logic [7:0] rc [3] = '{8'h48, 8'h4A, 8'h4F};
    logic [15:0] rv [3] = '{16'h0, 16'h0BFF, 16'h0BFF};
    int num_errors = 0;
    int checks = 0;
    int rises;
    int gap;
    // unit clock offset so its edges never meet clk edges
    always #5 clk = ~clk;
    initial #3 forever #40 unit_clk = ~unit_clk;
    ftr_host_model host_u (.clk, .cmd_valid, .cmd_write, .cmd_word,
        .cmd_code, .cmd_wdata, .rsp_valid, .rsp_error, .rsp_rdata);
    ftr_fault_ctrl dut_u (.clk, .reset_n, .cmd_valid, .cmd_write, .cmd_word,
        .cmd_code, .cmd_wdata, .rsp_valid, .rsp_error, .rsp_rdata, .temp_meas,
        .current_meas, .ctrl_pin, .op_on, .unit_clk, .out_enable, .hot_fault,
        .current_warn, .lv_trip_level, .retry_busy);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // one command with expected read data and refusal flag
    task automatic rw(input logic wr, wd, input logic [7:0] c,
        input logic [15:0] d, ed, input logic ee);
        logic [15:0] rd;
        logic er;
        logic ok;
        host_u.xfer(wr, wd, c, d, rd, er, ok);
        chk(16'(ok), 16'h1);
        chk(16'(er), 16'(ee));
        chk(rd, ed);
    endtask
    // bounded wait for an output level
    task automatic wait_oe(input logic v, input int n);
        repeat (n) begin
            @(posedge clk);
            if (out_enable === v)
                break;
        end
        chk(16'(out_enable), 16'(v));
    endtask
    // set the action byte, then bring temperature to the trip level
    task automatic heat(input logic [7:0] act);
        rw(1, 0, 8'h50, {8'h0, act}, 16'h0, 0);
        @(posedge clk);
        temp_meas <= 16'h0064;
    endtask
    task automatic cool();
        @(posedge clk);
        temp_meas <= 16'h0032;
        repeat (100) @(posedge clk);
    endtask
    // counts output turn-ons and the last spacing in cycles
    task automatic count_on(input int n);
        int last;
        logic prev;
        rises = 0;
        last = 0;
        prev = out_enable;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (out_enable === 1'b1 && prev === 1'b0) begin
                gap = i - last;
                last = i;
                rises++;
            end
            prev = out_enable;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog, well beyond the few thousand cycles of the tests
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rw(0, 1, rc[i], 16'h0, rv[i], 0);
            rw(1, 1, rc[i], 16'h0064, 16'h0, 0);
            rw(0, 1, rc[i], 16'h0, 16'h0064, 0);
        end
        chk(lv_trip_level, 16'h0064);
        rw(1, 1, 8'h50, 16'h00C0, 16'h0, 1);
        rw(1, 0, 8'h4F, 16'h0011, 16'h0, 1);
        rw(0, 0, 8'h99, 16'h0, 16'h0, 1);
        rw(0, 0, 8'h50, 16'h0, 16'h0080, 0);
        wait_oe(1, 20);
        // fault ignored: output stays on
        heat(8'h00);
        repeat (40) @(posedge clk);
        chk(16'(out_enable & hot_fault), 16'h1);
        cool();
        rw(1, 0, 8'h03, 16'h0, 16'h0, 0);
        chk(16'(hot_fault), 16'h0);
        // latched off until the status bit is cleared
        heat(8'hC0);
        wait_oe(0, 10);
        cool();
        chk(16'(out_enable), 16'h0);
        rw(0, 0, 8'h7D, 16'h0, 16'h0080, 0);
        rw(1, 0, 8'h7D, 16'h0080, 16'h0, 0);
        wait_oe(1, 10);
        // two attempts two units apart, then off for good
        heat(8'h91);
        count_on(300);
        chk(16'(rises), 16'h2);
        chk(16'(gap), 16'h10);
        chk(16'(out_enable | retry_busy), 16'h0);
        cool();
        rw(1, 0, 8'h03, 16'h0, 16'h0, 0);
        wait_oe(1, 10);
        // endless attempts until commanded off
        heat(8'hB8);
        count_on(200);
        chk(16'(rises > 8), 16'h1);
        chk(16'(gap), 16'h8);
        op_on <= 1'b0;
        temp_meas <= 16'h0032;
        repeat (20) @(posedge clk);
        chk(16'(out_enable | retry_busy), 16'h0);
        op_on <= 1'b1;
        wait_oe(1, 10);
        // run on for 2^d units, then latch since no retry is set
        for (int d = 2; d < 8; d += 5) begin
            heat({5'b01000, 3'(d)});
            repeat ((8 << d) - 12) @(posedge clk);
            chk(16'(out_enable), 16'h1);
            repeat (24) @(posedge clk);
            chk(16'(out_enable), 16'h0);
            cool();
            chk(16'(out_enable), 16'h0);
            rw(1, 0, 8'h03, 16'h0, 16'h0, 0);
            wait_oe(1, 10);
        end
        // warning only strictly above the limit; output untouched
        current_meas <= 16'h0064;
        repeat (4) @(posedge clk);
        chk(16'(current_warn), 16'h0);
        current_meas <= 16'h0065;
        repeat (4) @(posedge clk);
        chk(16'(current_warn & out_enable), 16'h1);
        current_meas <= 16'h0;
        rw(0, 0, 8'h7B, 16'h0, 16'h0020, 0);
        rw(1, 0, 8'h7B, 16'h0020, 16'h0, 0);
        chk(16'(current_warn), 16'h0);
        // a latch ended first by the pin off and on, then by a reset
        for (int k = 0; k < 2; k++) begin
            heat(8'hC0);
            wait_oe(0, 10);
            cool();
            if (k == 0) begin
                ctrl_pin <= 1'b0;
            end else begin
                reset_n <= 1'b0;
            end
            repeat (16) @(posedge clk);
            chk(16'(out_enable | hot_fault), 16'h0);
            ctrl_pin <= 1'b1;
            reset_n <= 1'b1;
            wait_oe(1, 10);
        end
        rw(0, 1, 8'h4F, 16'h0, 16'h0BFF, 0);
        rw(0, 0, 8'h50, 16'h0, 16'h0080, 0);
        give_verdict();
    end
endmodule // ftr_fault_ctrl_tb_top
`default_nettype wire
